// >>> logic/sfm_consts.vh
// constants for the serial flash fetch master: opcodes, setup data, timing
// assumes a single clock at the rate given below; included by bare name
`ifndef SFM_CONSTS_VH
`define SFM_CONSTS_VH

// flash opcodes and setup data
`define SFM_OP_FAST_READ  8'h0B
`define SFM_OP_WREN       8'h06
`define SFM_OP_WVCR       8'h81
`define SFM_VCR_DATA      8'h8B
`define SFM_OP_EN4B       8'hB7
`define SFM_DUMMY_BYTE    8'h00

// density above which four-byte addressing is needed
`define SFM_MBITS_3B_MAX  128

// clock rate and chip-select deselect time
`define SFM_CLK_MHZ       200
`define SFM_DESEL_NS      50
// least time, rounded up to whole cycles
`define SFM_DESEL_CYC     ((`SFM_DESEL_NS * `SFM_CLK_MHZ + 999) / 1000)

// reset values of the serial pins
`define SFM_RST_SCK       1'b0
`define SFM_RST_CS_N      1'b1
`define SFM_RST_MOSI      1'b0

`endif

// >>> logic/sfm_fetch_master.v
// serial flash fetch master: setup commands once after reset, then fast reads
// assumes one flash on a mode-0 bus, miso from a pin, user side on CLK_I
//
// What this block does
// - four-wire full duplex port, block is master
// - port present only with replacement or classification
// - one flash, used only as data source
// - reads use fast read opcode 0x0B
// - write enable 0x06 sent only when enabled
// - volatile config write 0x81 then 0x8B
// - byte engine, eight dummy cycles before data
// - four-byte entry 0xB7 sent before reads
// - four-byte entry forced above 128 Mbit
// - auto profile, up to 128 Mbit: no setup, three-byte address
// - above 128 Mbit: four-byte entry with every profile, write enable and config write only with profiles 0 and 1
// - two alternative profiles also supported
// - serial clock is input clock halved
// - read data sampled two cycles after launch
`timescale 1ns/1ps
`include "sfm_consts.vh"

module sfm_fetch_master #(
    parameter integer ENABLE_REPLACEMENT    = 1,   // correction by replacement
    parameter integer ENABLE_CLASSIFICATION = 1,   // error classification
    parameter integer STORAGE_MBITS         = 128, // flash density needed
    parameter integer FLASH_PROFILE         = 0    // 0 auto, 1 wren+wvcr, 2 en4b only
) (
    input  wire        CLK_I,
    input  wire        ARST_N_I,
    input  wire        RD_REQ_I,
    input  wire [31:0] RD_ADDR_I,
    input  wire [15:0] RD_LEN_I,
    output wire        READY_O,
    output wire [7:0]  DATA_O,
    output wire        DATA_VLD_O,
    output wire        SCK_O,
    output wire        CS_N_O,
    output wire        MOSI_O,
    input  wire        MISO_I
);

    // port exists only when a consumer of stored data is built in
    localparam PORT_ON = (ENABLE_REPLACEMENT != 0) || (ENABLE_CLASSIFICATION != 0);
    localparam BIG     = STORAGE_MBITS > `SFM_MBITS_3B_MAX;
    // effective setup options from profile and density
    localparam OPT_WREN = (FLASH_PROFILE == 1) ? 1 :
                          (FLASH_PROFILE == 2) ? 0 : (BIG ? 1 : 0);
    localparam OPT_WVCR = (FLASH_PROFILE == 1) ? 1 :
                          (FLASH_PROFILE == 2) ? 0 : (BIG ? 1 : 0);
    localparam OPT_EN4B = BIG ? 1 : ((FLASH_PROFILE == 2) ? 1 : 0);

    // sequencer steps
    localparam [2:0] ST_WREN1 = 3'h0;
    localparam [2:0] ST_WVCR  = 3'h1;
    localparam [2:0] ST_WREN2 = 3'h2;
    localparam [2:0] ST_EN4B  = 3'h3;
    localparam [2:0] ST_READY = 3'h4;
    localparam [2:0] ST_READ  = 3'h5;
    localparam [2:0] ST_OFF   = 3'h6;

    // frame engine states
    localparam [1:0] FE_IDLE  = 2'h0;
    localparam [1:0] FE_SHIFT = 2'h1;
    localparam [1:0] FE_GAP   = 2'h2;

    localparam integer DESEL_CYC = `SFM_DESEL_CYC;        // deselect time in cycles
    localparam [3:0]   GAP_LAST  = DESEL_CYC[3:0] - 4'h1; // counter load, cut to 4 bits

    // whether a setup step is built in
    function step_on;
        input [2:0] s;
        begin
            case (s)
                ST_WREN1: step_on = (OPT_WREN != 0);
                ST_WVCR:  step_on = (OPT_WVCR != 0);
                ST_WREN2: step_on = (OPT_WREN != 0) && (OPT_WVCR != 0)
                                    && (OPT_EN4B != 0);
                ST_EN4B:  step_on = (OPT_EN4B != 0);
                default:  step_on = 1'b0;
            endcase
        end
    endfunction

    // first built-in step at or after s, else ready
    function [2:0] first_step;
        input [2:0] s;
        integer i;
        begin
            first_step = ST_READY;
            for (i = 3; i >= 0; i = i - 1) begin
                if ((i >= s) && step_on(i[2:0])) begin
                    first_step = i[2:0];
                end
            end
        end
    endfunction

    // bytes sent by the master in each frame before any read data
    function [2:0] hdr_len;
        input [2:0] s;
        begin
            case (s)
                ST_WVCR: hdr_len = 3'h2;
                ST_READ: hdr_len = (OPT_EN4B != 0) ? 3'h6 : 3'h5; // op, addr, dummy
                default: hdr_len = 3'h1;
            endcase
        end
    endfunction

    // byte idx of the frame for step s
    function [7:0] hdr_byte;
        input [2:0]  s;
        input [2:0]  idx;
        input [31:0] a;
        begin
            case (s)
                ST_WREN1, ST_WREN2: hdr_byte = `SFM_OP_WREN;
                ST_WVCR: hdr_byte = (idx == 3'h0) ? `SFM_OP_WVCR : `SFM_VCR_DATA;
                ST_EN4B: hdr_byte = `SFM_OP_EN4B;
                ST_READ: begin
                    case ({(OPT_EN4B != 0), idx})
                        4'h0, 4'h8: hdr_byte = `SFM_OP_FAST_READ;
                        4'h9:       hdr_byte = a[31:24];
                        4'h1, 4'hA: hdr_byte = a[23:16];
                        4'h2, 4'hB: hdr_byte = a[15:8];
                        4'h3, 4'hC: hdr_byte = a[7:0];
                        default:    hdr_byte = `SFM_DUMMY_BYTE;
                    endcase
                end
                default: hdr_byte = `SFM_DUMMY_BYTE;
            endcase
        end
    endfunction

    localparam [2:0] SEQ_RST = PORT_ON ? first_step(ST_WREN1) : ST_OFF;

    reg  [1:0]  state_ff;    // frame engine state
    reg  [2:0]  seq_ff;      // sequencer step
    reg         sck_ff;      // serial clock
    reg         cs_n_ff;     // chip select, active low
    reg         mosi_ff;     // serial data out
    reg  [7:0]  sh_ff;       // tx shift, msb on the wire
    reg  [2:0]  bit_ff;      // bit within byte
    reg  [2:0]  idx_ff;      // header byte index
    reg         rx_ff;       // current byte is read data
    reg  [15:0] rem_ff;      // read bytes left
    reg  [31:0] addr_ff;     // read address
    reg  [3:0]  gap_ff;      // deselect counter
    reg  [3:0]  strb_ff;     // sample strobe delay line
    reg  [3:0]  lst_ff;      // last-bit tag delay line
    reg         miso_s1_ff;  // synchroniser first stage
    reg         miso_s2_ff;  // synchroniser second stage
    reg  [7:0]  rx_sh_ff;    // rx shift
    reg  [7:0]  data_ff;     // completed byte
    reg         vld_ff;      // byte valid pulse
    reg         ready_ff;    // accepts a read

    reg  [1:0]  nxt_state;
    reg  [2:0]  nxt_seq;
    reg         nxt_sck;
    reg         nxt_cs_n;
    reg         nxt_mosi;
    reg  [7:0]  nxt_sh;
    reg  [2:0]  nxt_bit;
    reg  [2:0]  nxt_idx;
    reg         nxt_rx;
    reg  [15:0] nxt_rem;
    reg  [31:0] nxt_addr;
    reg  [3:0]  nxt_gap;
    reg         nxt_strb;
    reg         nxt_lst;
    reg  [7:0]  ld_byte;     // byte loaded at a byte boundary

    // frame engine and sequencer
    always @* begin
        nxt_state = state_ff;
        nxt_seq   = seq_ff;
        nxt_sck   = sck_ff;
        nxt_cs_n  = cs_n_ff;
        nxt_mosi  = mosi_ff;
        nxt_sh    = sh_ff;
        nxt_bit   = bit_ff;
        nxt_idx   = idx_ff;
        nxt_rx    = rx_ff;
        nxt_rem   = rem_ff;
        nxt_addr  = addr_ff;
        nxt_gap   = gap_ff;
        nxt_strb  = 1'b0;
        nxt_lst   = 1'b0;
        ld_byte   = `SFM_DUMMY_BYTE;
        case (state_ff)
            FE_IDLE: begin
                // setup steps start by themselves, reads on request
                if ((seq_ff <= ST_EN4B) ||
                    ((seq_ff == ST_READY) && RD_REQ_I && (RD_LEN_I != 16'h0))) begin
                    if (seq_ff == ST_READY) begin
                        nxt_seq  = ST_READ;
                        nxt_addr = RD_ADDR_I;
                        nxt_rem  = RD_LEN_I;
                    end
                    ld_byte   = hdr_byte(nxt_seq, 3'h0, RD_ADDR_I);
                    nxt_state = FE_SHIFT;
                    nxt_cs_n  = 1'b0;
                    nxt_sh    = ld_byte;
                    nxt_mosi  = ld_byte[7];
                    nxt_bit   = 3'h0;
                    nxt_idx   = 3'h0;
                    nxt_rx    = 1'b0;
                end
            end
            FE_SHIFT: begin
                nxt_sck = ~sck_ff;
                if (sck_ff) begin
                    // falling edge: next bit or byte boundary
                    if (bit_ff != 3'h7) begin
                        nxt_bit  = bit_ff + 3'h1;
                        nxt_sh   = {sh_ff[6:0], 1'b0};
                        nxt_mosi = sh_ff[6];
                        nxt_strb = rx_ff;
                        nxt_lst  = rx_ff && (bit_ff == 3'h6);
                    end else if ((rx_ff && (rem_ff == 16'h1)) ||
                                 (!rx_ff && (idx_ff == hdr_len(seq_ff) - 3'h1) &&
                                  (seq_ff != ST_READ))) begin
                        // frame done, deselect
                        nxt_state = FE_GAP;
                        nxt_cs_n  = 1'b1;
                        nxt_mosi  = 1'b0;
                        nxt_gap   = GAP_LAST;
                    end else begin
                        if (rx_ff) begin
                            nxt_rem = rem_ff - 16'h1;
                        end else if (idx_ff == hdr_len(seq_ff) - 3'h1) begin
                            nxt_rx = 1'b1;
                        end else begin
                            nxt_idx = idx_ff + 3'h1;
                            ld_byte = hdr_byte(seq_ff, idx_ff + 3'h1, addr_ff);
                        end
                        nxt_sh   = ld_byte;
                        nxt_mosi = ld_byte[7];
                        nxt_bit  = 3'h0;
                        nxt_strb = nxt_rx;
                    end
                end
            end
            FE_GAP: begin
                if (gap_ff == 4'h0) begin
                    nxt_state = FE_IDLE;
                    nxt_seq   = (seq_ff == ST_READ) ? ST_READY
                                : first_step(seq_ff + 3'h1);
                end else begin
                    nxt_gap = gap_ff - 4'h1;
                end
            end
            default: begin
                nxt_state = FE_IDLE;
                nxt_cs_n  = 1'b1;
                nxt_sck   = 1'b0;
            end
        endcase
    end

    // state registers
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_ff <= FE_IDLE;
            seq_ff   <= SEQ_RST;
            sck_ff   <= `SFM_RST_SCK;
            cs_n_ff  <= `SFM_RST_CS_N;
            mosi_ff  <= `SFM_RST_MOSI;
            sh_ff    <= 8'h00;
            bit_ff   <= 3'h0;
            idx_ff   <= 3'h0;
            rx_ff    <= 1'b0;
            rem_ff   <= 16'h0000;
            addr_ff  <= 32'h00000000;
            gap_ff   <= 4'h0;
            strb_ff  <= 4'h0;
            lst_ff   <= 4'h0;
            ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            seq_ff   <= nxt_seq;
            sck_ff   <= nxt_sck;
            cs_n_ff  <= nxt_cs_n;
            mosi_ff  <= nxt_mosi;
            sh_ff    <= nxt_sh;
            bit_ff   <= nxt_bit;
            idx_ff   <= nxt_idx;
            rx_ff    <= nxt_rx;
            rem_ff   <= nxt_rem;
            addr_ff  <= nxt_addr;
            gap_ff   <= nxt_gap;
            strb_ff  <= {strb_ff[2:0], nxt_strb};  // launch edge, then +1..+3
            lst_ff   <= {lst_ff[2:0], nxt_lst};
            ready_ff <= (nxt_state == FE_IDLE) && (nxt_seq == ST_READY);
        end
    end

    // miso: two-stage synchroniser, then capture at launch + 4 edges
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            miso_s1_ff <= 1'b0;
            miso_s2_ff <= 1'b0;
            rx_sh_ff   <= 8'h00;
            data_ff    <= 8'h00;
            vld_ff     <= 1'b0;
        end else begin
            miso_s1_ff <= MISO_I;
            miso_s2_ff <= miso_s1_ff;
            vld_ff     <= 1'b0;
            if (strb_ff[3]) begin
                // pin value taken two cycles after the launching fall
                rx_sh_ff <= {rx_sh_ff[6:0], miso_s2_ff};
                if (lst_ff[3]) begin
                    data_ff <= {rx_sh_ff[6:0], miso_s2_ff};
                    vld_ff  <= 1'b1;
                end
            end
        end
    end

    // outputs straight from flip-flops
    assign READY_O    = ready_ff;
    assign DATA_O     = data_ff;
    assign DATA_VLD_O = vld_ff;
    assign SCK_O      = sck_ff;
    assign CS_N_O     = cs_n_ff;
    assign MOSI_O     = mosi_ff;

endmodule

// >>> verification/sfm_fetch_master_sva.sv
// checker for the fetch master serial port timing
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module sfm_fetch_master_sva (
    input wire        CLK_I,
    input wire        ARST_N_I,
    input wire        RD_REQ_I,
    input wire [31:0] RD_ADDR_I,
    input wire [15:0] RD_LEN_I,
    input wire        READY_O,
    input wire [7:0]  DATA_O,
    input wire        DATA_VLD_O,
    input wire        SCK_O,
    input wire        CS_N_O,
    input wire        MOSI_O,
    input wire        MISO_I
);
    logic [3:0] gap_ff; // cycles select has stood high, saturating

    // count deselect time so the gap between frames can be judged
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            gap_ff <= 4'hF;
        end else if (!CS_N_O) begin
            gap_ff <= 4'h0;
        end else if (gap_ff != 4'hF) begin
            gap_ff <= gap_ff + 4'h1;
        end
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);

    sck_idle_low_a: assert property (CS_N_O |-> !SCK_O)
        else $error("serial clock high while deselected");
    sck_high_one_a: assert property (SCK_O |=> !SCK_O)
        else $error("serial clock high longer than one cycle");
    sck_low_one_a: assert property ((!SCK_O && !CS_N_O) |=> (SCK_O || CS_N_O))
        else $error("serial clock low longer than one cycle in frame");
    mosi_hold_a: assert property (SCK_O |-> $stable(MOSI_O))
        else $error("mosi moved while serial clock high");
    ready_idle_a: assert property (READY_O |-> CS_N_O)
        else $error("ready while a frame runs");
    read_start_a: assert property ((READY_O && RD_REQ_I && RD_LEN_I != 16'h0000)
        |=> !READY_O ##1 (!CS_N_O && !MOSI_O))
        else $error("read frame did not start with opcode msb");
    vld_sample_a: assert property (DATA_VLD_O |->
        $past(SCK_O, 3) && !$past(SCK_O, 4) && !$past(CS_N_O, 3))
        else $error("data strobe not at its fixed distance from last rise");
    vld_pulse_a: assert property (DATA_VLD_O |=> !DATA_VLD_O)
        else $error("data strobe longer than one cycle");
    deselect_gap_a: assert property ($fell(CS_N_O) |-> gap_ff >= 4'hA)
        else $error("deselect gap too short");
endmodule

bind sfm_fetch_master sfm_fetch_master_sva u_sva (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
    .RD_REQ_I(RD_REQ_I), .RD_ADDR_I(RD_ADDR_I), .RD_LEN_I(RD_LEN_I), .READY_O(READY_O),
    .DATA_O(DATA_O), .DATA_VLD_O(DATA_VLD_O), .SCK_O(SCK_O), .CS_N_O(CS_N_O),
    .MOSI_O(MOSI_O), .MISO_I(MISO_I));

// >>> verification/sfm_flash_model.sv
// behavioural serial flash: logs commands, answers fast reads
// assumes mode 0 and one select frame per command
`timescale 1ns/1ps
module sfm_flash_model (
    input  wire  sck_i,
    input  wire  cs_n_i,
    input  wire  mosi_i,
    output logic miso_o
);
    logic [7:0]  rx_q[$]; // every byte seen on mosi
    logic [7:0]  sh;      // incoming shift register
    logic [7:0]  op;      // opcode of this frame
    logic [7:0]  cur;     // byte being sent
    logic [31:0] adr;     // read start address
    int          nbits;   // bits taken this frame
    int          frames;  // completed frames
    int          errs;    // protocol faults seen
    int          hdr;     // bytes before read data
    int          k;       // data bit index
    bit          wel;     // write enable latch
    bit          four_b;  // four-byte address mode
    bit          sel;     // a frame has begun, so a rise of select ends one

    initial begin
        miso_o = 1'b0;
    end
    // header: opcode, address, one dummy byte of eight clocks
    always @* hdr = four_b ? 6 : 5;
    // new frame
    always @(negedge cs_n_i) begin
        nbits = 0;
        sel = 1'b1;
        op = 8'h00;
        adr = 32'h0000_0000;
    end
    // end of frame: partial bytes are faults, data line inverted 1 ns later
    always @(posedge cs_n_i) begin
        // the rise of select out of reset is not the end of a frame
        if (sel) begin
            frames++;
            if (nbits % 8 != 0) errs++;
        end
        sel = 1'b0;
        #1 miso_o = ~miso_o;
    end
    // take mosi on rising clock, decode whole bytes
    always @(posedge sck_i) begin
        if (!cs_n_i) begin
            sh = {sh[6:0], mosi_i};
            nbits++;
            if (nbits % 8 == 0) begin
                rx_q.push_back(sh);
                if (nbits == 8) begin
                    op = sh;
                    if (sh == 8'h81 && !wel) errs++;
                    if (sh == 8'h81) wel = 1'b0;
                    if (sh == 8'h06) wel = 1'b1;
                    if (sh == 8'hB7) four_b = 1'b1;
                end else if (op == 8'h81 && nbits == 16 && sh != 8'h8B) begin
                    errs++;
                end else if (op == 8'h0B && nbits <= 8 * (hdr - 1)) begin
                    adr = {adr[23:0], sh};
                end
            end
        end
    end
    // launch data msb first on falling clock, address rising
    always @(negedge sck_i) begin
        if (!cs_n_i && op == 8'h0B && nbits >= 8 * hdr) begin
            k = nbits - 8 * hdr;
            cur = adr[7:0] + k / 8;
            cur = cur ^ 8'h3C;
            miso_o = cur[7 - k % 8];
        end
    end
endmodule

// >>> verification/tb_top.sv
// testbench: setup sequence, refused request, fast reads
// assumes the flash model on the serial side, 200 MHz clock
`timescale 1ns/1ps
module tb_top;
    logic        clk;
    logic        arst_n;
    logic        rd_req;
    logic [31:0] rd_addr;
    logic [15:0] rd_len;
    logic        ready;
    logic [7:0]  data;
    logic        data_vld;
    logic        sck;
    logic        cs_n;
    logic        mosi;
    logic        miso;
    int          n_errors;
    int          checks_done;
    int          base;
    int          i;

    sfm_fetch_master #(.STORAGE_MBITS(256)) u_dut (.CLK_I(clk), .ARST_N_I(arst_n),
        .RD_REQ_I(rd_req), .RD_ADDR_I(rd_addr), .RD_LEN_I(rd_len), .READY_O(ready),
        .DATA_O(data), .DATA_VLD_O(data_vld), .SCK_O(sck), .CS_N_O(cs_n),
        .MOSI_O(mosi), .MISO_I(miso));
    sfm_flash_model u_flash (.sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) chk(8'h00, 8'h01, "ready timeout");
    endtask

    // one read; every byte and the header bytes are compared
    task automatic rd(input logic [31:0] a, input logic [15:0] len);
        int n;
        int k;
        wait_ready;
        base = u_flash.rx_q.size();
        rd_req <= 1'b1;
        rd_addr <= a;
        rd_len <= len;
        @(posedge clk);
        rd_req <= 1'b0;
        for (k = 0; k < len; k++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (data_vld !== 1'b1 && n < 400);
            chk(data, (a[7:0] + k[7:0]) ^ 8'h3C, "read byte");
        end
        wait_ready;
        chk(u_flash.rx_q[base], 8'h0B, "read opcode");
        for (k = 0; k < 4; k++) begin
            chk(u_flash.rx_q[base + 1 + k], a[31 - 8 * k -: 8], "address byte");
        end
        chk(u_flash.rx_q[base + 5], 8'h00, "dummy byte");
    endtask

    task automatic report_and_stop;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // watchdog well past the expected run
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop;
    end

    initial begin
        arst_n = 1'b0;
        rd_req = 1'b0;
        rd_addr = 32'h0000_0000;
        rd_len = 16'h0000;
        repeat (16) @(posedge clk);
        chk({7'h00, ready}, 8'h00, "ready in reset");
        arst_n <= 1'b1;
        wait_ready;
        chk(u_flash.rx_q[0], 8'h06, "first enable");
        chk(u_flash.rx_q[1], 8'h81, "config write");
        chk(u_flash.rx_q[2], 8'h8B, "config data");
        chk(u_flash.rx_q[3], 8'h06, "second enable");
        chk(u_flash.rx_q[4], 8'hB7, "four-byte entry");
        chk(u_flash.frames[7:0], 8'h04, "setup frames");
        // zero length request is ignored
        @(posedge clk);
        rd_req <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        repeat (3) @(posedge clk);
        chk({7'h00, ready}, 8'h01, "ready after empty request");
        chk(u_flash.frames[7:0], 8'h04, "no frame for empty request");
        rd(32'h00FF_FFFE, 16'h0004);
        rd(32'h0100_0010, 16'h0001);
        chk(u_flash.errs[7:0], 8'h00, "flash protocol faults");
        report_and_stop;
    end
endmodule
